/* src/tsf_pkg.sv */
// constants shared by the timer channel status flag block
// assumes a 32-bit apb register bus and five timer channels
package tsf_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int TSF_NCH = 5;
  localparam int TSF_AW = 8;
  localparam int TSF_CW = 16;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, one word per register)
  // ----------------------------------------------------------------
  localparam logic [7:0] TSF_OFF_STAT0 = 8'h00;
  localparam logic [7:0] TSF_OFF_STAT_LAST = 8'h10;
  localparam logic [7:0] TSF_OFF_OVF_EN = 8'h14;

  // ----------------------------------------------------------------
  // channel_status field positions
  // ----------------------------------------------------------------
  localparam int TSF_BIT_DIR = 7;
  localparam int TSF_BIT_RSV = 6;
  localparam int TSF_BIT_UNF = 5;
  localparam int TSF_BIT_OVF = 4;
  localparam int TSF_BIT_COMPARE_CAPTURE_FLAG_D = 3;

  // ----------------------------------------------------------------
  // which channels carry which flag
  // ----------------------------------------------------------------
  localparam logic [4:0] TSF_UNF_CH = 5'h06;
  localparam logic [4:0] TSF_COMPARE_CAPTURE_FLAG_D_CH = 5'h19;
  localparam int TSF_CPWM_CH = 4;

  // ----------------------------------------------------------------
  // counter values and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] TSF_CNT_MIN = 16'h0000;
  localparam logic [15:0] TSF_CNT_ONE = 16'h0001;
  localparam logic [15:0] TSF_CNT_MAX = 16'hffff;
  localparam logic [4:0] TSF_DIR_RST = 5'h1f;
  localparam logic [4:0] TSF_OVF_EN_RST = 5'h00;
  localparam logic [4:0] TSF_EQ_RST = 5'h1f;
  localparam logic TSF_FLAG_RST = 1'b0;

endpackage : tsf_pkg

/* src/tsf_flag_cell.sv */
// one clear-after-read status flag of a timer channel
// assumes the caller gives one-cycle pulses for set, arm and write
`timescale 1ns/10ps
`default_nettype none
module tsf_flag_cell
#(
  parameter bit IMPL = 1'b1
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // events
  input wire logic set_evt,
  input wire logic arm_evt,
  input wire logic wr_evt,
  input wire logic wr_val,
  // state
  output logic flag_q
);
  import tsf_pkg::*;

  logic armed_q;

  // ----------------------------------------------------------------
  // arming: a read that returned 1 allows the next write to clear
  // ----------------------------------------------------------------
  // any write consumes the arming, so a stale read cannot clear later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      armed_q <= 1'b0;
    else if (!IMPL || wr_evt)
      armed_q <= 1'b0;
    else if (arm_evt)
      armed_q <= 1'b1;
  end

  // ----------------------------------------------------------------
  // flag: hardware set beats software clear
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_q <= TSF_FLAG_RST;
    else if (!IMPL)
      flag_q <= 1'b0;
    else if (set_evt)
      flag_q <= 1'b1;
    else if (wr_evt && !wr_val && armed_q)
      flag_q <= 1'b0;
  end

endmodule : tsf_flag_cell
`default_nettype wire

/* src/tsf_status.sv */
// status flags of a five-channel timer, reached over apb
// assumes counters and capture events arrive synchronous to pclk
`timescale 1ns/10ps
`default_nettype none
module tsf_status
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [tsf_pkg::TSF_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer side
  input wire logic [tsf_pkg::TSF_CW-1:0] channel_counter [tsf_pkg::TSF_NCH],
  input wire logic [tsf_pkg::TSF_CW-1:0] general_register_d [tsf_pkg::TSF_NCH],
  input wire logic [tsf_pkg::TSF_NCH-1:0] count_up,
  input wire logic [tsf_pkg::TSF_NCH-1:0] phase_mode,
  input wire logic cpwm_mode,
  input wire logic [tsf_pkg::TSF_NCH-1:0] grd_compare_mode,
  input wire logic [tsf_pkg::TSF_NCH-1:0] capture_d,
  // interrupt requests
  output logic [tsf_pkg::TSF_NCH-1:0] overflow_interrupt_request
);
  import tsf_pkg::*;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  // status register index of an address, hit low when not a status word
  function automatic logic [3:0] stat_sel(input logic [TSF_AW-1:0] a);
    logic [3:0] r;
    r = 4'h0;
    if (a[1:0] == 2'b00 && a >= TSF_OFF_STAT0 && a <= TSF_OFF_STAT_LAST)
    begin
      r[3] = 1'b1;
      r[2:0] = a[4:2];
    end
    return r;
  endfunction : stat_sel

  // assemble one channel_status byte; bits 2..0 belong elsewhere
  function automatic logic [7:0] stat_word(input logic ch0, input logic dir,
                                           input logic unf, input logic ovf,
                                           input logic compare_capture_flag_d);
    logic [7:0] w;
    w = 8'h00;
    w[TSF_BIT_DIR] = ch0 ? 1'b1 : dir;
    w[TSF_BIT_RSV] = 1'b1;
    w[TSF_BIT_UNF] = unf;
    w[TSF_BIT_OVF] = ovf;
    w[TSF_BIT_COMPARE_CAPTURE_FLAG_D] = compare_capture_flag_d;
    return w;
  endfunction : stat_word

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [TSF_NCH-1:0] irq_q;
  logic [TSF_NCH-1:0] dir_q;
  logic [TSF_NCH-1:0] ovf_en_q;
  logic [TSF_NCH-1:0] eq_prev_q;
  logic [TSF_CW-1:0] cnt_prev_q [TSF_NCH];
  logic [TSF_NCH-1:0] unf_q;
  logic [TSF_NCH-1:0] ovf_q;
  logic [TSF_NCH-1:0] compare_capture_flag_d_q;
  logic [TSF_NCH-1:0] unf_evt;
  logic [TSF_NCH-1:0] ovf_evt;
  logic [TSF_NCH-1:0] compare_capture_flag_d_evt;
  logic [TSF_NCH-1:0] eq_now;
  logic [TSF_NCH-1:0] wr_ch;
  logic [TSF_NCH-1:0] rd_ch;
  logic [7:0] stat_w [TSF_NCH];
  logic [3:0] sel;
  logic xfer_done;
  logic is_en_reg;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign overflow_interrupt_request = irq_q;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // one wait state: read data is captured the cycle before pready, so it stands when sampled
  assign sel = stat_sel(paddr);
  assign is_en_reg = (paddr == TSF_OFF_OVF_EN);
  assign xfer_done = psel && penable && pready_q;

  // ready and error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else if (psel && penable && !pready_q)
    begin
      pready_q <= 1'b1;
      pslverr_q <= !(sel[3] || is_en_reg);
    end
    else
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // read data, captured in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (psel && penable && !pready_q && !pwrite)
    begin
      if (sel[3])
        prdata_q <= {24'h00_0000, stat_w[sel[2:0]]};
      else if (is_en_reg)
        prdata_q <= {27'h000_0000, ovf_en_q};
      else
        prdata_q <= 32'h0000_0000;
    end
  end

  // overflow interrupt enables, one per channel
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ovf_en_q <= TSF_OVF_EN_RST;
    else if (xfer_done && pwrite && is_en_reg)
      ovf_en_q <= pwdata[TSF_NCH-1:0];
  end

  // ----------------------------------------------------------------
  // counter observation
  // ----------------------------------------------------------------
  // direction follows the counter; software writes to it are dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dir_q <= TSF_DIR_RST;
    else
      dir_q <= count_up;
  end

  // previous counter and match state, for edge detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      eq_prev_q <= TSF_EQ_RST;
      for (int i = 0; i < TSF_NCH; i++)
        cnt_prev_q[i] <= TSF_CNT_MIN;
    end
    else
    begin
      eq_prev_q <= eq_now;
      for (int i = 0; i < TSF_NCH; i++)
        cnt_prev_q[i] <= channel_counter[i];
    end
  end

  // interrupt request from flag and enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_q <= '0;
    else
      irq_q <= ovf_q & ovf_en_q;
  end

  // ----------------------------------------------------------------
  // per-channel events and flags
  // ----------------------------------------------------------------
  // a match counts once, when equality is reached, so a cleared flag
  // is not set again while the counter sits on the compare value
  for (genvar k = 0; k < TSF_NCH; k++)
  begin : g_ch
    logic cpwm_dec;
    assign cpwm_dec = (k == TSF_CPWM_CH) && cpwm_mode
                      && cnt_prev_q[k] == TSF_CNT_ONE
                      && channel_counter[k] == TSF_CNT_MIN;
    assign eq_now[k] = (channel_counter[k] == general_register_d[k]);
    assign unf_evt[k] = phase_mode[k] && cnt_prev_q[k] == TSF_CNT_MIN
                        && channel_counter[k] == TSF_CNT_MAX;
    assign ovf_evt[k] = (cnt_prev_q[k] == TSF_CNT_MAX
                         && channel_counter[k] == TSF_CNT_MIN)
                        || cpwm_dec;
    assign compare_capture_flag_d_evt[k] = grd_compare_mode[k] ? (eq_now[k] && !eq_prev_q[k])
                                             : capture_d[k];
    assign wr_ch[k] = xfer_done && pwrite && sel[3] && sel[2:0] == k;
    assign rd_ch[k] = xfer_done && !pwrite && sel[3] && sel[2:0] == k;
    assign stat_w[k] = stat_word(k == 0, dir_q[k], unf_q[k], ovf_q[k],
                                 compare_capture_flag_d_q[k]);

    // underflow exists only where phase counting exists
    tsf_flag_cell #(.IMPL(TSF_UNF_CH[k])) u_unf
    (
      .pclk(pclk),
      .presetn(presetn),
      .set_evt(unf_evt[k]),
      .arm_evt(rd_ch[k] && prdata_q[TSF_BIT_UNF]),
      .wr_evt(wr_ch[k]),
      .wr_val(pwdata[TSF_BIT_UNF]),
      .flag_q(unf_q[k])
    );

    tsf_flag_cell #(.IMPL(1'b1)) u_ovf
    (
      .pclk(pclk),
      .presetn(presetn),
      .set_evt(ovf_evt[k]),
      .arm_evt(rd_ch[k] && prdata_q[TSF_BIT_OVF]),
      .wr_evt(wr_ch[k]),
      .wr_val(pwdata[TSF_BIT_OVF]),
      .flag_q(ovf_q[k])
    );

    tsf_flag_cell #(.IMPL(TSF_COMPARE_CAPTURE_FLAG_D_CH[k])) u_compare_capture_flag_d
    (
      .pclk(pclk),
      .presetn(presetn),
      .set_evt(compare_capture_flag_d_evt[k]),
      .arm_evt(rd_ch[k] && prdata_q[TSF_BIT_COMPARE_CAPTURE_FLAG_D]),
      .wr_evt(wr_ch[k]),
      .wr_val(pwdata[TSF_BIT_COMPARE_CAPTURE_FLAG_D]),
      .flag_q(compare_capture_flag_d_q[k])
    );
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_read_ovf4;
    rd_ch[4] && prdata_q[TSF_BIT_OVF];
  endsequence
  sequence s_zero_ovf4;
    wr_ch[4] && !pwdata[TSF_BIT_OVF] && !ovf_evt[4];
  endsequence
  sequence s_read_unf1;
    rd_ch[1] && prdata_q[TSF_BIT_UNF];
  endsequence
  sequence s_zero_unf1;
    wr_ch[1] && !pwdata[TSF_BIT_UNF] && !unf_evt[1];
  endsequence
  property p_apb_wait;
    psel && penable && !pready_q |=> pready_q ##1 !pready_q;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb wait state wrong");
  property p_dir;
    ##1 stat_w[2][TSF_BIT_DIR] == $past(count_up[2]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction bit wrong");
  property p_ones;
    stat_w[0][7:6] == 2'b11 && stat_w[3][TSF_BIT_RSV];
  endproperty
  a_ones: assert property (p_ones) else $error("reserved one bit wrong");
  property p_zeros;
    !stat_w[0][TSF_BIT_UNF] && !stat_w[4][TSF_BIT_UNF] && !stat_w[2][TSF_BIT_COMPARE_CAPTURE_FLAG_D];
  endproperty
  a_zeros: assert property (p_zeros) else $error("reserved zero bit wrong");
  property p_unf_set;
    phase_mode[1] && cnt_prev_q[1] == TSF_CNT_MIN
      && channel_counter[1] == TSF_CNT_MAX |=> unf_q[1];
  endproperty
  a_unf_set: assert property (p_unf_set) else $error("underflow not set");
  // a transfer takes at least three edges, so no other write fits between read and write
  property p_unf_clr;
    s_read_unf1 ##[3:4] s_zero_unf1 |=> !unf_q[1];
  endproperty
  a_unf_clr: assert property (p_unf_clr) else $error("underflow not cleared");
  property p_ovf_set;
    cnt_prev_q[3] == TSF_CNT_MAX && channel_counter[3] == TSF_CNT_MIN |=> ovf_q[3];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not set");
  property p_cpwm;
    cpwm_mode && cnt_prev_q[4] == TSF_CNT_ONE && channel_counter[4] == TSF_CNT_MIN |=> ovf_q[4];
  endproperty
  a_cpwm: assert property (p_cpwm) else $error("pwm overflow not set");
  property p_ovf_clr;
    s_read_ovf4 ##[3:4] s_zero_ovf4 |=> !ovf_q[4];
  endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("overflow not cleared");
  property p_wr_one;
    wr_ch[4] && pwdata[TSF_BIT_OVF] && !ovf_evt[4] |=> $stable(ovf_q[4]);
  endproperty
  a_wr_one: assert property (p_wr_one) else $error("write one changed flag");
  property p_cmp;
    grd_compare_mode[0] && eq_now[0] && !eq_prev_q[0] |=> compare_capture_flag_d_q[0];
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare flag not set");
  property p_cap;
    !grd_compare_mode[3] && capture_d[3] |=> compare_capture_flag_d_q[3];
  endproperty
  a_cap: assert property (p_cap) else $error("capture flag not set");
  property p_compare_capture_flag_d_keep;
    wr_ch[0] && !pwdata[TSF_BIT_COMPARE_CAPTURE_FLAG_D] && !g_ch[0].u_compare_capture_flag_d.armed_q
      && !compare_capture_flag_d_evt[0] |=> $stable(compare_capture_flag_d_q[0]);
  endproperty
  a_compare_capture_flag_d_keep: assert property (p_compare_capture_flag_d_keep) else $error("flag d changed");
  property p_irq;
    ##1 overflow_interrupt_request[4] == $past(ovf_q[4] && ovf_en_q[4]);
  endproperty
  a_irq: assert property (p_irq) else $error("overflow request wrong");
  property p_set_wins;
    wr_ch[4] && !pwdata[TSF_BIT_OVF] && ovf_evt[4] |=> ovf_q[4];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clear");
endmodule : tsf_status
`default_nettype wire

/* verif/tsf_status_tb.sv */
// self-checking bench for the timer channel status flag block
// assumes the one-wait-state apb slave and register map of tsf_pkg
`timescale 1ns/10ps
`default_nettype none
module tsf_status_tb;
  import tsf_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [TSF_AW-1:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [TSF_CW-1:0] cnt [TSF_NCH] = '{default: 16'h0000};
  logic [TSF_CW-1:0] grd [TSF_NCH] = '{default: 16'h1234};
  logic [TSF_NCH-1:0] count_up = 5'h1f;
  logic [TSF_NCH-1:0] phase_mode = 5'h00;
  logic cpwm_mode = 1'b0;
  logic [TSF_NCH-1:0] cmp_mode = 5'h00;
  logic [TSF_NCH-1:0] capture_d = 5'h00;
  logic [TSF_NCH-1:0] irq;
  logic [31:0] rdat;
  logic err;
  int n_errors = 0;
  int n_compared = 0;

  // 125 mhz clock
  always #4 pclk = ~pclk;

  tsf_status uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .channel_counter(cnt), .general_register_d(grd),
    .count_up(count_up), .phase_mode(phase_mode), .cpwm_mode(cpwm_mode),
    .grd_compare_mode(cmp_mode), .capture_d(capture_d),
    .overflow_interrupt_request(irq)
  );

  // ----------------------------------------------------------------
  // apb master and checking helpers
  // ----------------------------------------------------------------
  // request held until pready is sampled high; no wait count assumed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd

  // two counter samples, then let the flag settle
  task automatic evt(input int ch, input logic [15:0] a, input logic [15:0] b);
    @(posedge pclk);
    cnt[ch] <= a;
    @(posedge pclk);
    cnt[ch] <= b;
    repeat (3) @(posedge pclk);
  endtask : evt

  task automatic report_and_stop;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  // watchdog: the tests need well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    report_and_stop;
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, then writes of the reserved-safe pattern
    for (int k = 0; k < TSF_NCH; k++)
    begin
      rd(8'(4 * k), 32'h0000_00c0);
      xfer(1'b1, 8'(4 * k), 32'h0000_00c0);
      chk(32'(err), 32'h0);
    end
    rd(TSF_OFF_OVF_EN, 32'h0000_0000);
    // unmapped word is refused
    rd(8'h18, 32'h0);
    chk(32'(err), 32'h1);
    xfer(1'b1, 8'h18, 32'hff);
    chk(32'(err), 32'h1);
    // direction bit follows the counter, not in channel 0
    @(posedge pclk);
    count_up <= 5'h1a;
    repeat (3) @(posedge pclk);
    rd(8'h08, 32'h0000_0040);
    rd(8'h00, 32'h0000_00c0);
    count_up <= 5'h1f;
    // overflow wrap on channel 3; its underflow bit stays reserved
    evt(3, 16'hffff, 16'h0000);
    rd(8'h0c, 32'h0000_00d0);
    xfer(1'b1, 8'h0c, 32'h0000_00d0);
    xfer(1'b1, 8'h0c, 32'h0000_00c0);
    rd(8'h0c, 32'h0000_00d0);
    xfer(1'b1, 8'h0c, 32'h0000_00c0);
    rd(8'h0c, 32'h0000_00c0);
    // downward step to zero without complementary pwm
    evt(3, 16'h0001, 16'h0000);
    rd(8'h0c, 32'h0000_00c0);
    // underflow in phase counting on channel 1
    phase_mode <= 5'h02;
    evt(1, 16'h0000, 16'hffff);
    rd(8'h04, 32'h0000_00e0);
    xfer(1'b1, 8'h04, 32'h0000_00e0);
    rd(8'h04, 32'h0000_00e0);
    xfer(1'b1, 8'h04, 32'h0000_00c0);
    rd(8'h04, 32'h0000_00c0);
    // complementary pwm step to zero on channel 4
    cpwm_mode <= 1'b1;
    evt(4, 16'h0001, 16'h0000);
    rd(8'h10, 32'h0000_00d0);
    xfer(1'b1, 8'h10, 32'h0000_00d0);
    rd(8'h10, 32'h0000_00d0);
    // overflow request follows flag and enable
    xfer(1'b1, TSF_OFF_OVF_EN, 32'h0000_0010);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h10);
    xfer(1'b1, TSF_OFF_OVF_EN, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h00);
    // new event lands on the completion edge of the clearing write
    @(posedge pclk);
    cnt[4] <= 16'h0001;
    rd(8'h10, 32'h0000_00d0);
    fork
      begin
        @(posedge pclk iff (psel && penable));
        cnt[4] <= 16'h0000;
      end
      xfer(1'b1, 8'h10, 32'h0000_00c0);
    join
    repeat (2) @(posedge pclk);
    rd(8'h10, 32'h0000_00d0);
    xfer(1'b1, 8'h10, 32'h0000_00c0);
    rd(8'h10, 32'h0000_00c0);
    // compare match on channels 0 and 1 (bit 3 reserved in 1)
    cmp_mode <= 5'h03;
    evt(0, 16'h1233, 16'h1234);
    evt(1, 16'h1233, 16'h1234);
    rd(8'h00, 32'h0000_00c8);
    rd(8'h04, 32'h0000_00c0);
    xfer(1'b1, 8'h00, 32'h0000_00c8);
    xfer(1'b1, 8'h00, 32'h0000_00c0);
    rd(8'h00, 32'h0000_00c8);
    xfer(1'b1, 8'h00, 32'h0000_00c0);
    rd(8'h00, 32'h0000_00c0);
    // capture into register d on channels 3 and 4
    @(posedge pclk);
    capture_d <= 5'h18;
    @(posedge pclk);
    capture_d <= 5'h00;
    repeat (3) @(posedge pclk);
    rd(8'h10, 32'h0000_00c8);
    rd(8'h0c, 32'h0000_00c8);
    report_and_stop;
  end
endmodule : tsf_status_tb
`default_nettype wire
